// ### design/restart_pkg.sv
package restart_pkg;

    // Register byte addresses on the APB bus.
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] DELAY_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFFSET = 8'h0C;
    localparam logic [7:0] IRQ_EN_OFFSET = 8'h10;
    localparam logic [7:0] IRQ_CLR_OFFSET = 8'h14;

    // Control register field positions.
    localparam int CTRL_RET_LSB = 0;
    localparam int CTRL_COUPLED_BIT = 2;
    localparam int CTRL_BRIGHT_DEP_BIT = 3;
    localparam int CTRL_APP_LSB = 4;

    // Status register field positions.
    localparam int STAT_MOTION_BIT = 0;
    localparam int STAT_PRESENCE_BIT = 1;
    localparam int STAT_INDEP_BIT = 2;
    localparam int STAT_DISABLED_BIT = 3;
    localparam int STAT_RAISED_BIT = 4;
    localparam int STAT_RUNNING_BIT = 5;
    localparam int STAT_SAVED_BIT = 6;

    // Interrupt status bit positions.
    localparam int IRQ_WIDTH = 4;
    localparam int IRQ_START_BIT = 0;
    localparam int IRQ_END_BIT = 1;
    localparam int IRQ_RESTORE_BIT = 2;
    localparam int IRQ_DOWNLOAD_BIT = 3;

    // Values after reset.
    localparam logic [1:0] RET_RESET = 2'h0;
    localparam logic [1:0] APP_RESET = 2'h0;
    localparam logic [15:0] DELAY_RESET = 16'h003C;
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;

    // Delay tick timing: one delay unit is one tick.
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = (TICK_TIME_US * 1000 * 1000) / CLK_PERIOD_PS;

    // Behaviour selected for the return of bus voltage.
    typedef enum logic [1:0] {
        RET_NONE = 2'b00,
        RET_DETECT = 2'b01,
        RET_RESTORE = 2'b10,
        RET_DISABLE = 2'b11
    } return_opt_type;

    // Application type of the function block.
    typedef enum logic [1:0] {
        APP_SINGLE = 2'b00,
        APP_MAIN = 2'b01,
        APP_EXT = 2'b10,
        APP_SPARE = 2'b11
    } app_type_type;

    // Motion state of the function block.
    typedef enum logic {
        MODE_BASIC = 1'b0,
        MODE_DETECT = 1'b1
    } mode_type;

endpackage : restart_pkg

// ### design/delay_timer.sv
`timescale 1ns/1ps
`default_nettype none

module delay_timer #(
    parameter int TICK_CYCLES = restart_pkg::TICK_CYCLES,
    parameter int WIDTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic stop,
    input wire logic [WIDTH-1:0] delay,
    output logic running
);

    localparam int DW = $clog2(TICK_CYCLES + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYCLES - 1);

    typedef struct packed {
        logic [DW-1:0] div;
        logic [WIDTH-1:0] count;
        logic running;
    } timer_state_type;

    timer_state_type t_reg;
    timer_state_type t_next;
    logic tick;

    // Prescaler gives a one-cycle tick; start loads the count, a zero delay counts as one.
    always_comb begin
        t_next = t_reg;
        tick = (t_reg.div == DIV_LAST);
        t_next.div = tick ? '0 : t_reg.div + 1'b1;
        if (stop) begin
            t_next.running = 1'b0;
        end else if (start) begin
            t_next.running = 1'b1;
            t_next.div = '0;
            t_next.count = (delay == '0) ? WIDTH'(1) : delay;
        end else if (t_reg.running && tick) begin
            t_next.count = t_reg.count - 1'b1;
            if (t_reg.count == WIDTH'(1)) begin
                t_next.running = 1'b0;
            end
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign running = t_reg.running;

endmodule : delay_timer

`default_nettype wire

// ### design/detector_restart_state_logic.sv
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module detector_restart_state_logic #(
    parameter int TICK_CYCLES = restart_pkg::TICK_CYCLES,
    parameter int DELAY_WIDTH = 16,
    parameter bit FIRST_FUNCTION_BLOCK = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic bus_ok,
    input wire logic download_done,
    input wire logic block_active,
    input wire logic motion,
    input wire logic below_twilight,
    input wire logic light_sufficient,
    input wire logic lock_req,
    output logic motion_state,
    output logic presence,
    output logic independent_mode,
    output logic disabled,
    output logic start_tel,
    output logic end_tel,
    output logic light_up,
    output logic light_down,
    output logic irq
);

    typedef struct packed {
        restart_pkg::mode_type mode;
        logic presence;
        logic independent;
        logic disabled;
        logic raised;
        logic start_tel;
        logic end_tel;
        logic light_up;
        logic light_down;
        logic timer_start;
        logic timer_stop;
        logic bus_ok_d;
        restart_pkg::mode_type s_mode;
        logic s_presence;
        logic s_independent;
        logic s_disabled;
        logic s_raised;
        logic s_valid;
        restart_pkg::return_opt_type ret_opt;
        logic coupled;
        logic bright_dep;
        restart_pkg::app_type_type app;
        logic [DELAY_WIDTH-1:0] delay;
        logic [restart_pkg::IRQ_WIDTH-1:0] irq_stat;
        logic [restart_pkg::IRQ_WIDTH-1:0] irq_en;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_type;

    state_type r_reg;
    state_type r_next;
    logic timer_running;
    logic app_ok;
    logic coupled_eff;
    logic bus_return;
    logic download_hit;
    logic eligible;
    logic do_detect;
    logic do_restore;
    logic do_none;
    logic run;
    logic go_detect;
    logic go_end;
    logic go_basic;
    logic apb_setup;
    logic apb_commit;
    logic [restart_pkg::IRQ_WIDTH-1:0] events;
    logic [restart_pkg::IRQ_WIDTH-1:0] clr_mask;

    // Detection hold delay with its own tick prescaler; its expiry ends the detection.
    delay_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .WIDTH(DELAY_WIDTH)
    ) delay_timer_i (
        .pclk(pclk),
        .presetn(presetn),
        .start(r_reg.timer_start),
        .stop(r_reg.timer_stop),
        .delay(r_reg.delay),
        .running(timer_running)
    );

    // Decode which restart action applies in this cycle.
    always_comb begin
        app_ok = (r_reg.app == restart_pkg::APP_SINGLE) || (r_reg.app == restart_pkg::APP_MAIN);
        coupled_eff = FIRST_FUNCTION_BLOCK && r_reg.coupled && app_ok;
        bus_return = bus_ok && !r_reg.bus_ok_d;
        download_hit = download_done && bus_ok && app_ok;
        eligible = bus_return && block_active && !download_done && app_ok;
        do_detect = eligible && (r_reg.ret_opt == restart_pkg::RET_DETECT);
        do_restore = eligible && (r_reg.ret_opt == restart_pkg::RET_RESTORE);
        do_none = eligible && !do_detect && !do_restore;
        run = bus_ok && block_active && !bus_return && !download_hit;
    end

    // Main next-state logic: restart behaviour, detection, light control, registers.
    always_comb begin
        r_next = r_reg;
        r_next.start_tel = 1'b0;
        r_next.end_tel = 1'b0;
        r_next.light_up = 1'b0;
        r_next.light_down = 1'b0;
        r_next.timer_start = 1'b0;
        r_next.timer_stop = 1'b0;
        r_next.bus_ok_d = bus_ok;
        events = '0;
        go_detect = 1'b0;
        go_end = 1'b0;
        go_basic = 1'b0;
        clr_mask = '0;

        // The copy follows the live state only while the bus is up, so it holds the pre-loss state.
        if (bus_ok && !bus_return) begin
            r_next.s_mode = r_reg.mode;
            r_next.s_presence = r_reg.presence;
            r_next.s_independent = r_reg.independent;
            r_next.s_disabled = r_reg.disabled;
            r_next.s_raised = r_reg.raised;
            r_next.s_valid = 1'b1;
        end

        // Download wins over a bus return in the same cycle.
        if (download_hit) begin
            go_basic = 1'b1;
            events[restart_pkg::IRQ_DOWNLOAD_BIT] = 1'b1;
        end else if (do_detect) begin
            go_detect = 1'b1;
        end else if (do_restore) begin
            r_next.mode = r_reg.s_mode;
            r_next.presence = r_reg.s_presence;
            r_next.independent = r_reg.s_independent;
            r_next.disabled = r_reg.s_disabled;
            r_next.raised = r_reg.s_raised;
            r_next.timer_start = (r_reg.s_mode == restart_pkg::MODE_DETECT);
            r_next.timer_stop = (r_reg.s_mode != restart_pkg::MODE_DETECT);
            events[restart_pkg::IRQ_RESTORE_BIT] = 1'b1;
        end else if (do_none) begin
            go_basic = 1'b1;
        end else if (run) begin
            r_next.disabled = lock_req;
            if (lock_req) begin
                if (r_reg.mode == restart_pkg::MODE_DETECT) begin
                    go_end = 1'b1;
                end
            end else if (motion && (r_reg.mode == restart_pkg::MODE_DETECT)) begin
                r_next.timer_start = 1'b1;
            end else if (motion && (r_reg.independent || below_twilight)) begin
                go_detect = 1'b1;
            end else if ((r_reg.mode == restart_pkg::MODE_DETECT) && !timer_running
                && !r_reg.timer_start) begin
                go_end = 1'b1;
            end
        end

        // Entry into an active detection.
        if (go_detect) begin
            r_next.mode = restart_pkg::MODE_DETECT;
            r_next.timer_start = 1'b1;
            r_next.disabled = 1'b0;
            events[restart_pkg::IRQ_START_BIT] = 1'b1;
            if (coupled_eff) begin
                r_next.presence = 1'b1;
                if (!light_sufficient && !r_reg.raised) begin
                    r_next.light_up = 1'b1;
                    r_next.raised = 1'b1;
                end
            end else begin
                r_next.start_tel = 1'b1;
                r_next.independent = r_reg.bright_dep ? below_twilight : 1'b1;
            end
        end

        // End of detection: autonomous blocks send the end telegram, coupled ones lower light they raised.
        if (go_end) begin
            r_next.mode = restart_pkg::MODE_BASIC;
            r_next.timer_stop = 1'b1;
            events[restart_pkg::IRQ_END_BIT] = 1'b1;
            if (coupled_eff) begin
                r_next.presence = 1'b0;
                r_next.light_down = r_reg.raised;
                r_next.raised = 1'b0;
            end else begin
                r_next.end_tel = 1'b1;
            end
        end

        // Basic state without any telegram.
        if (go_basic) begin
            r_next.mode = restart_pkg::MODE_BASIC;
            r_next.presence = 1'b0;
            r_next.disabled = 1'b0;
            r_next.raised = 1'b0;
            r_next.timer_stop = 1'b1;
        end

        // APB: setup answers one cycle later; the access completes at the pready edge.
        apb_setup = psel && penable && !r_reg.pready;
        apb_commit = psel && penable && r_reg.pready;
        r_next.pready = apb_setup;
        if (apb_setup) begin
            r_next.pslverr = 1'b0;
            r_next.prdata = '0;
            unique case (paddr)
                restart_pkg::CTRL_OFFSET: begin
                    r_next.prdata[restart_pkg::CTRL_RET_LSB +: 2] = r_reg.ret_opt;
                    r_next.prdata[restart_pkg::CTRL_COUPLED_BIT] = r_reg.coupled;
                    r_next.prdata[restart_pkg::CTRL_BRIGHT_DEP_BIT] = r_reg.bright_dep;
                    r_next.prdata[restart_pkg::CTRL_APP_LSB +: 2] = r_reg.app;
                end
                restart_pkg::DELAY_OFFSET: begin
                    r_next.prdata[DELAY_WIDTH-1:0] = r_reg.delay;
                end
                restart_pkg::STATUS_OFFSET: begin
                    r_next.prdata[restart_pkg::STAT_MOTION_BIT] = r_reg.mode;
                    r_next.prdata[restart_pkg::STAT_PRESENCE_BIT] = r_reg.presence;
                    r_next.prdata[restart_pkg::STAT_INDEP_BIT] = r_reg.independent;
                    r_next.prdata[restart_pkg::STAT_DISABLED_BIT] = r_reg.disabled;
                    r_next.prdata[restart_pkg::STAT_RAISED_BIT] = r_reg.raised;
                    r_next.prdata[restart_pkg::STAT_RUNNING_BIT] = timer_running;
                    r_next.prdata[restart_pkg::STAT_SAVED_BIT] = r_reg.s_valid;
                end
                restart_pkg::IRQ_STAT_OFFSET: begin
                    r_next.prdata[restart_pkg::IRQ_WIDTH-1:0] = r_reg.irq_stat;
                end
                restart_pkg::IRQ_EN_OFFSET: begin
                    r_next.prdata[restart_pkg::IRQ_WIDTH-1:0] = r_reg.irq_en;
                end
                restart_pkg::IRQ_CLR_OFFSET: begin
                    r_next.prdata = '0;
                end
                default: begin
                    r_next.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_commit && pwrite) begin
            unique case (paddr)
                restart_pkg::CTRL_OFFSET: begin
                    r_next.ret_opt = restart_pkg::return_opt_type'(pwdata[restart_pkg::CTRL_RET_LSB +: 2]);
                    r_next.coupled = pwdata[restart_pkg::CTRL_COUPLED_BIT];
                    r_next.bright_dep = pwdata[restart_pkg::CTRL_BRIGHT_DEP_BIT];
                    r_next.app = restart_pkg::app_type_type'(pwdata[restart_pkg::CTRL_APP_LSB +: 2]);
                end
                restart_pkg::DELAY_OFFSET: begin
                    r_next.delay = pwdata[DELAY_WIDTH-1:0];
                end
                restart_pkg::IRQ_EN_OFFSET: begin
                    r_next.irq_en = pwdata[restart_pkg::IRQ_WIDTH-1:0];
                end
                restart_pkg::IRQ_CLR_OFFSET: begin
                    clr_mask = pwdata[restart_pkg::IRQ_WIDTH-1:0];
                end
                default: begin
                    clr_mask = '0;
                end
            endcase
        end

        // Sticky events: a new event wins over a clear in the same cycle.
        r_next.irq_stat = (r_reg.irq_stat & ~clr_mask) | events;
        r_next.irq = |(r_next.irq_stat & r_next.irq_en);
    end

    // State register; the block comes up in the basic state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.ret_opt <= restart_pkg::return_opt_type'(restart_pkg::RET_RESET);
            r_reg.app <= restart_pkg::app_type_type'(restart_pkg::APP_RESET);
            r_reg.delay <= DELAY_WIDTH'(restart_pkg::DELAY_RESET);
            r_reg.irq_en <= restart_pkg::IRQ_EN_RESET;
            r_reg.independent <= 1'b1;
            r_reg.s_independent <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs come straight from the state register.
    assign pready = r_reg.pready;
    assign prdata = r_reg.prdata;
    assign pslverr = r_reg.pslverr;
    assign motion_state = r_reg.mode;
    assign presence = r_reg.presence;
    assign independent_mode = r_reg.independent;
    assign disabled = r_reg.disabled;
    assign start_tel = r_reg.start_tel;
    assign end_tel = r_reg.end_tel;
    assign light_up = r_reg.light_up;
    assign light_down = r_reg.light_down;
    assign irq = r_reg.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Checks on the restart behaviour.
    a_detect_restart: assert property (do_detect |=> r_reg.mode && r_reg.timer_start ##1 timer_running)
        else $error("restart option did not start detection and delay");
    a_start_telegram: assert property (do_detect && !coupled_eff |=> start_tel && !light_up)
        else $error("restart option did not send start telegram");
    a_twilight_mode: assert property (do_detect && !coupled_eff && r_reg.bright_dep |=> independent_mode == $past(below_twilight))
        else $error("twilight switch-over wrong after restart");
    a_end_expiry: assert property ($fell(timer_running) && r_reg.mode && run && !motion && !lock_req && !r_reg.timer_start && !coupled_eff |=> end_tel && !motion_state)
        else $error("end of detection missing after delay");
    a_presence_set: assert property (do_detect && coupled_eff |=> presence && motion_state && !start_tel)
        else $error("coupled restart did not raise presence");
    a_light_quiet: assert property (go_detect && coupled_eff && light_sufficient |=> !light_up)
        else $error("light raised although bright enough");
    a_restore_exact: assert property (do_restore |=> motion_state == $past(r_reg.s_mode) && presence == $past(r_reg.s_presence) && disabled == $past(r_reg.s_disabled))
        else $error("restored state differs from saved copy");
    a_skip_inactive: assert property (bus_return && !block_active && !download_done |=> !start_tel && !r_reg.timer_start && $stable(motion_state))
        else $error("bus return acted on an inactive block");
    a_ext_no_download: assert property (download_done && !app_ok |=> !r_reg.irq_stat[restart_pkg::IRQ_DOWNLOAD_BIT] || $past(r_reg.irq_stat[restart_pkg::IRQ_DOWNLOAD_BIT]))
        else $error("download behaviour on an extension block");
    a_download_basic: assert property (download_hit |=> !motion_state && !presence && !disabled && !start_tel && !end_tel && r_reg.timer_stop)
        else $error("download did not enter basic state quietly");
    a_none_return: assert property (do_none |=> !motion_state && !presence && !start_tel && !end_tel)
        else $error("no-reaction return left active state");
    a_saved_copy: assert property (!bus_ok |=> $stable(r_reg.s_mode) && $stable(r_reg.s_presence))
        else $error("saved copy changed while bus was down");

    // Main scenarios.
    c_detect_restart: cover property (do_detect ##[1:200] end_tel);
    c_restore: cover property (do_restore && r_reg.s_mode);
    c_coupled_cycle: cover property (light_up ##[1:20] light_down);
    c_download: cover property (download_hit && r_reg.mode);

endmodule : detector_restart_state_logic

`default_nettype wire

// ### sim/telegram_sink.sv
`timescale 1ns/1ps
`default_nettype none

// Stands for the other bus devices: it counts every telegram the block sends out.
module telegram_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start_tel,
    input wire logic end_tel,
    input wire logic light_up,
    input wire logic light_down,
    output logic [31:0] n_start,
    output logic [31:0] n_end,
    output logic [31:0] n_up,
    output logic [31:0] n_down
);
    // A pulse sampled high at a rising edge is one received telegram.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_start <= 32'h0;
            n_end <= 32'h0;
            n_up <= 32'h0;
            n_down <= 32'h0;
        end else begin
            n_start <= n_start + {31'h0, start_tel};
            n_end <= n_end + {31'h0, end_tel};
            n_up <= n_up + {31'h0, light_up};
            n_down <= n_down + {31'h0, light_down};
        end
    end
endmodule : telegram_sink
`default_nettype wire

// ### sim/detector_restart_state_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none

module detector_restart_state_logic_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, n_start, n_end, n_up, n_down, s0, e0;
    logic bus_ok, download_done, block_active, motion, below_twilight, light_sufficient, lock_req;
    logic motion_state, presence, independent_mode, disabled, start_tel, end_tel;
    logic light_up, light_down, irq;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    // The delay timer ticks every four clocks to keep the run short.
    detector_restart_state_logic #(.TICK_CYCLES(4)) detector_restart_state_logic_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .bus_ok(bus_ok), .download_done(download_done), .block_active(block_active),
        .motion(motion), .below_twilight(below_twilight), .light_sufficient(light_sufficient),
        .lock_req(lock_req), .motion_state(motion_state), .presence(presence),
        .independent_mode(independent_mode), .disabled(disabled), .start_tel(start_tel),
        .end_tel(end_tel), .light_up(light_up), .light_down(light_down), .irq(irq));

    telegram_sink telegram_sink_i (.pclk(pclk), .presetn(presetn), .start_tel(start_tel),
        .end_tel(end_tel), .light_up(light_up), .light_down(light_down), .n_start(n_start),
        .n_end(n_end), .n_up(n_up), .n_down(n_down));

    // Clock of 4 ns period.
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // A hung run is cut off and counted as a mismatch.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic results;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results

    task automatic check_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check_bit

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check_word(what, exp, rd);
    endtask : rd_chk

    // Bus voltage drops for three cycles and then returns.
    task automatic bus_ret;
        bus_ok <= 1'b0;
        tick(3);
        bus_ok <= 1'b1;
        tick(4);
    endtask : bus_ret

    task automatic pulse(input logic dl);
        if (dl) download_done <= 1'b1;
        else motion <= 1'b1;
        tick(1);
        download_done <= 1'b0;
        motion <= 1'b0;
        tick(4);
        s0 = n_start;
        e0 = n_end;
    endtask : pulse

    // Waits, bounded, until the detection has ended.
    task automatic wait_idle;
        for (int i = 0; i < 300 && motion_state !== 1'b0; i++) @(posedge pclk);
        tick(3);
    endtask : wait_idle

    // Main sequence of tests.
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {bus_ok, download_done, motion, below_twilight, light_sufficient, lock_req} = '0;
        block_active = 1'b1;
        tick(10);
        presetn <= 1'b1;
        tick(1);
        rd_chk("ctrl", restart_pkg::CTRL_OFFSET, 32'h0);
        rd_chk("delay", restart_pkg::DELAY_OFFSET, 32'h3C);
        rd_chk("status", restart_pkg::STATUS_OFFSET, 32'h4);
        rd_chk("unmapped", 8'h40, 32'h0);
        check_bit("slverr", 1'b1, err);
        apb(1'b1, restart_pkg::DELAY_OFFSET, 32'h14);
        apb(1'b1, restart_pkg::IRQ_EN_OFFSET, 32'hF);
        $display("test registers done");
        apb(1'b1, restart_pkg::CTRL_OFFSET, 32'h1);
        bus_ret();
        check_bit("motion", 1'b1, motion_state);
        check_word("starts", 32'h1, n_start);
        check_bit("irq", 1'b1, irq);
        wait_idle();
        check_word("ends", 32'h1, n_end);
        rd_chk("irq stat", restart_pkg::IRQ_STAT_OFFSET, 32'h3);
        apb(1'b1, restart_pkg::IRQ_CLR_OFFSET, 32'hF);
        tick(3);
        check_bit("irq", 1'b0, irq);
        apb(1'b1, restart_pkg::CTRL_OFFSET, 32'h9);
        bus_ret();
        check_word("starts", 32'h2, n_start);
        check_bit("independent", 1'b0, independent_mode);
        wait_idle();
        below_twilight <= 1'b1;
        bus_ret();
        check_bit("independent", 1'b1, independent_mode);
        wait_idle();
        $display("test restart done");
        apb(1'b1, restart_pkg::CTRL_OFFSET, 32'h5);
        bus_ret();
        check_bit("presence", 1'b1, presence);
        check_word("ups", 32'h1, n_up);
        wait_idle();
        check_bit("presence", 1'b0, presence);
        check_word("downs", 32'h1, n_down);
        light_sufficient <= 1'b1;
        bus_ret();
        wait_idle();
        check_word("ups", 32'h1, n_up);
        check_word("downs", 32'h1, n_down);
        light_sufficient <= 1'b0;
        apb(1'b1, restart_pkg::CTRL_OFFSET, 32'h4);
        pulse(1'b0);
        bus_ret();
        check_bit("presence", 1'b0, presence);
        check_word("starts", s0, n_start);
        $display("test coupled done");
        apb(1'b1, restart_pkg::CTRL_OFFSET, 32'h2);
        pulse(1'b0);
        bus_ret();
        check_bit("motion", 1'b1, motion_state);
        wait_idle();
        bus_ret();
        check_bit("motion", 1'b0, motion_state);
        check_word("starts", s0, n_start);
        apb(1'b1, restart_pkg::CTRL_OFFSET, 32'h1);
        block_active <= 1'b0;
        bus_ret();
        check_bit("motion", 1'b0, motion_state);
        block_active <= 1'b1;
        bus_ok <= 1'b0;
        tick(3);
        bus_ok <= 1'b1;
        pulse(1'b1);
        check_bit("motion", 1'b0, motion_state);
        $display("test restore done");
        pulse(1'b0);
        pulse(1'b1);
        check_bit("motion", 1'b0, motion_state);
        check_bit("disabled", 1'b0, disabled);
        check_word("starts", s0, n_start);
        check_word("ends", e0, n_end);
        apb(1'b1, restart_pkg::CTRL_OFFSET, 32'h5);
        pulse(1'b0);
        lock_req <= 1'b1;
        tick(2);
        check_bit("disabled", 1'b1, disabled);
        lock_req <= 1'b0;
        block_active <= 1'b0;
        pulse(1'b1);
        block_active <= 1'b1;
        check_bit("disabled", 1'b0, disabled);
        check_bit("presence", 1'b0, presence);
        check_bit("motion", 1'b0, motion_state);
        apb(1'b1, restart_pkg::CTRL_OFFSET, 32'h21);
        pulse(1'b0);
        pulse(1'b1);
        check_bit("motion", 1'b1, motion_state);
        wait_idle();
        $display("test download done");
        results();
    end
endmodule : detector_restart_state_logic_bench
`default_nettype wire
